// [timer_group_pkg.sv]
// Constants, field layout and mode codes of the timer group mode control block
package timer_group_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_CTRL_IDX = 32'h0080031a;
  localparam logic [31:0] RUN_CTRL_IDX = 32'h00800320;
  localparam logic [31:0] STATUS_IDX = 32'h00800322;
  localparam logic [31:0] MEAS_CH0_IDX = 32'h00800324;
  localparam logic [31:0] MEAS_CH3_IDX = 32'h00800326;
  localparam logic [31:0] COUNT_CH0_IDX = 32'h00800328;
  localparam logic [31:0] COUNT_CH3_IDX = 32'h0080032a;

  // ----------------------------------------------------------------
  // Mode control word layout
  // ----------------------------------------------------------------
  localparam int MODE_W = 3;
  localparam int CH3_EEN_BIT = 0;
  localparam int CH3_MODE_LSB = 1;
  localparam int CH2_RSV_BIT = 4;
  localparam int CH2_MODE_LSB = 5;
  localparam int CH1_RSV_BIT = 8;
  localparam int CH1_MODE_LSB = 9;
  localparam int CH0_SRC_BIT = 12;
  localparam int CH0_MODE_LSB = 13;
  localparam logic [15:0] MODE_CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Run control and status layout
  // ----------------------------------------------------------------
  localparam int RUN_CH0_BIT = 0;
  localparam int RUN_CH3_BIT = 3;
  localparam logic [3:0] RUN_CTRL_RESET = 4'h0;
  localparam int STAT_CH0_CAP_BIT = 0;
  localparam int STAT_CH3_CAP_BIT = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Counter values
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RELOAD = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'hffff;
  localparam logic [15:0] MEASURE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Enable/measure source codes of the shared ch3/ch4 field
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_EVENT_BUS2 = 2'h2;
  localparam logic [1:0] SRC_EVENT_BUS3 = 2'h3;

  typedef enum logic [2:0]
  {
    MODE_SINGLE_SHOT = 3'h0,
    MODE_DELAYED_SHOT = 3'h1,
    MODE_CONTINUOUS = 3'h2,
    MODE_PULSE_WIDTH = 3'h3,
    MODE_MEASURE_CLEAR = 3'h4,
    MODE_MEASURE_FREE = 3'h5,
    MODE_NOISE = 3'h6
  } op_mode_e;

  function automatic logic is_measure(input logic [2:0] mode);
    is_measure = (mode == MODE_MEASURE_CLEAR) || (mode == MODE_MEASURE_FREE);
  endfunction

  // Top two bits set means noise processing (11X)
  function automatic logic is_noise(input logic [2:0] mode);
    is_noise = mode[2] & mode[1];
  endfunction

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = {idx[29:0], 2'b00};
  endfunction

endpackage

// [measure_channel.sv]
// Measure-mode counter and capture latch of one capture-capable channel
module measure_channel
  import timer_group_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [2:0] i_mode,
  input wire logic i_ext_enable,
  input wire logic i_capture,
  // Results
  output logic [15:0] o_count,
  output logic [15:0] o_measure,
  output logic o_captured
);
  import timer_group_pkg::*;

  logic capture_prev_ff;
  logic [15:0] count_ff;
  logic [15:0] measure_ff;
  logic captured_ff;
  logic [15:0] nxt_count;
  wire capture_edge = i_capture & ~capture_prev_ff;
  wire measuring = is_measure(i_mode) & i_run;
  // Capture latches even with the external input gated off
  wire do_capture = measuring & capture_edge;
  // Reload only when the external input is admitted
  wire do_reload = do_capture & (i_mode == MODE_MEASURE_CLEAR) & i_ext_enable;

  always_comb
  begin
    nxt_count = count_ff;
    if (do_reload)
    begin
      nxt_count = COUNT_RELOAD;
    end
    else if (measuring & i_tick)
    begin
      // Natural wrap: 0000 minus one is ffff
      nxt_count = count_ff - 16'h0001;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      capture_prev_ff <= 1'b0;
      count_ff <= COUNT_RESET;
      measure_ff <= MEASURE_RESET;
      captured_ff <= 1'b0;
    end
    else
    begin
      capture_prev_ff <= i_capture;
      count_ff <= nxt_count;
      captured_ff <= do_capture;
      if (do_capture)
      begin
        measure_ff <= count_ff;
      end
    end
  end

  assign o_count = count_ff;
  assign o_measure = measure_ff;
  assign o_captured = captured_ff;
endmodule

// [timer_group_mode_control.sv]
// APB mode control word for timer channels 0 to 3 with capture handling
//
// Overview of operation
// - Bits 3..1 pick channel 3 mode
// - Bits 15..13 pick channel 0 mode
// - Bits 11..9 channel 1 mode, 11X banned
// - Bits 7..5 channel 2 mode, 11X banned
// - Bit 0 gates channel 3 external input
// - Bits 4 and 8 inert, read zero
// - Bit 12 routes pin three to channel 0
// - Channel 3 source comes from channel 4 word
// - Measure capture latches count even input gated
// - Channels 1 and 2 never capture
// - Measure-clear capture reloads counter to ffff, on channel 3 only with bit 0 set
// - Free-run capture leaves count, underflow wraps
//
// Added by the designer: the APB interface to the registers.
module timer_group_mode_control
  import timer_group_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Count tick and capture sources
  input wire logic i_count_tick,
  input wire logic i_timer_input_pin_three,
  input wire logic [3:0] i_input_event_bus,
  input wire logic [1:0] i_ch3_ch4_source_select,
  // Decoded control to the channel datapaths
  output logic [2:0] o_ch0_mode_select,
  output logic [2:0] o_ch1_mode_select,
  output logic [2:0] o_ch2_mode_select,
  output logic [2:0] o_ch3_mode_select,
  output logic o_ch3_external_input_enable,
  output logic o_ch0_source_select,
  // Enable/measure inputs after source selection
  output logic o_ch0_measure_input,
  output logic o_ch3_measure_input,
  // Capture results
  output logic [15:0] o_ch0_measure,
  output logic [15:0] o_ch3_measure,
  output logic o_ch0_captured,
  output logic o_ch3_captured
);
  import timer_group_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] ch0_mode_ff;
  logic [2:0] ch1_mode_ff;
  logic [2:0] ch2_mode_ff;
  logic [2:0] ch3_mode_ff;
  logic ch3_een_ff;
  logic ch0_src_ff;
  logic [3:0] run_ff;
  logic [3:0] status_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [3:0] nxt_status;
  logic [3:0] run_bits;

  logic [15:0] ch0_count;
  logic [15:0] ch3_count;
  logic [15:0] ch0_meas;
  logic [15:0] ch3_meas;
  logic ch0_cap;
  logic ch3_cap;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_mode = (i_paddr == byte_addr(MODE_CTRL_IDX));
  wire sel_run = (i_paddr == byte_addr(RUN_CTRL_IDX));
  wire sel_status = (i_paddr == byte_addr(STATUS_IDX));
  wire sel_meas0 = (i_paddr == byte_addr(MEAS_CH0_IDX));
  wire sel_meas3 = (i_paddr == byte_addr(MEAS_CH3_IDX));
  wire sel_count0 = (i_paddr == byte_addr(COUNT_CH0_IDX));
  wire sel_count3 = (i_paddr == byte_addr(COUNT_CH3_IDX));
  wire mapped = sel_mode | sel_run | sel_status | sel_meas0 | sel_meas3 |
                sel_count0 | sel_count3;
  wire read_only = sel_meas0 | sel_meas3 | sel_count0 | sel_count3;

  wire setup_phase = i_psel & ~i_penable;
  wire access_done = i_psel & i_penable;
  // Byte writes to the mode word are refused with an error
  wire half_ok = (i_pstrb[1:0] == 2'b11);
  wire bad_write = i_pwrite & ((sel_mode & ~half_ok) | read_only);
  wire setup_err = ~mapped | bad_write;
  wire wr_ok = access_done & i_pwrite & ~pslverr_ff;
  wire wr_mode = wr_ok & sel_mode;
  wire wr_run = wr_ok & sel_run;
  wire wr_status = wr_ok & sel_status;

  // ----------------------------------------------------------------
  // Write data fields
  // ----------------------------------------------------------------
  wire [2:0] wr_ch0_mode = i_pwdata[CH0_MODE_LSB +: MODE_W];
  wire [2:0] wr_ch1_mode = i_pwdata[CH1_MODE_LSB +: MODE_W];
  wire [2:0] wr_ch2_mode = i_pwdata[CH2_MODE_LSB +: MODE_W];
  wire [2:0] wr_ch3_mode = i_pwdata[CH3_MODE_LSB +: MODE_W];
  // Banned codes on channels 1 and 2 keep the previous mode
  wire ch1_mode_ok = ~is_noise(wr_ch1_mode);
  wire ch2_mode_ok = ~is_noise(wr_ch2_mode);

  // ----------------------------------------------------------------
  // Read-back of the mode word, reserved bits as zero
  // ----------------------------------------------------------------
  logic [15:0] mode_word;
  always_comb
  begin
    mode_word = MODE_CTRL_RESET;
    mode_word[CH3_EEN_BIT] = ch3_een_ff;
    mode_word[CH3_MODE_LSB +: MODE_W] = ch3_mode_ff;
    mode_word[CH2_RSV_BIT] = 1'b0;
    mode_word[CH2_MODE_LSB +: MODE_W] = ch2_mode_ff;
    mode_word[CH1_RSV_BIT] = 1'b0;
    mode_word[CH1_MODE_LSB +: MODE_W] = ch1_mode_ff;
    mode_word[CH0_SRC_BIT] = ch0_src_ff;
    mode_word[CH0_MODE_LSB +: MODE_W] = ch0_mode_ff;
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Taken in setup, so a running count reads one tick old
  wire [31:0] rd_value =
    sel_mode ? {16'h0000, mode_word} :
    sel_run ? {28'h0000000, run_ff} :
    sel_status ? {28'h0000000, status_ff} :
    sel_meas0 ? {16'h0000, ch0_meas} :
    sel_meas3 ? {16'h0000, ch3_meas} :
    sel_count0 ? {16'h0000, ch0_count} :
    sel_count3 ? {16'h0000, ch3_count} :
    32'h00000000;

  // ----------------------------------------------------------------
  // Mode control word
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ch0_mode_ff <= MODE_SINGLE_SHOT;
      ch1_mode_ff <= MODE_SINGLE_SHOT;
      ch2_mode_ff <= MODE_SINGLE_SHOT;
      ch3_mode_ff <= MODE_SINGLE_SHOT;
      ch3_een_ff <= 1'b0;
      ch0_src_ff <= 1'b0;
    end
    else if (wr_mode)
    begin
      ch0_mode_ff <= wr_ch0_mode;
      ch3_mode_ff <= wr_ch3_mode;
      ch3_een_ff <= i_pwdata[CH3_EEN_BIT];
      ch0_src_ff <= i_pwdata[CH0_SRC_BIT];
      if (ch1_mode_ok)
      begin
        ch1_mode_ff <= wr_ch1_mode;
      end
      if (ch2_mode_ok)
      begin
        ch2_mode_ff <= wr_ch2_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Run control write value
  // ----------------------------------------------------------------
  // Counters exist for channels 0 and 3 only; other run bits stay zero
  always_comb
  begin
    run_bits = 4'h0;
    run_bits[RUN_CH0_BIT] = i_pwdata[RUN_CH0_BIT];
    run_bits[RUN_CH3_BIT] = i_pwdata[RUN_CH3_BIT];
  end

  // ----------------------------------------------------------------
  // Run control and sticky capture status
  // ----------------------------------------------------------------
  // A capture in the clearing cycle survives: set wins over clear
  always_comb
  begin
    nxt_status = status_ff;
    if (wr_status)
    begin
      nxt_status = status_ff & ~i_pwdata[3:0];
    end
    nxt_status[STAT_CH0_CAP_BIT] = nxt_status[STAT_CH0_CAP_BIT] | ch0_cap;
    nxt_status[STAT_CH3_CAP_BIT] = nxt_status[STAT_CH3_CAP_BIT] | ch3_cap;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      run_ff <= RUN_CTRL_RESET;
      status_ff <= STATUS_RESET;
    end
    else
    begin
      status_ff <= nxt_status;
      if (wr_run)
      begin
        run_ff <= run_bits;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer: data and error sampled in setup, ready in access
  // ----------------------------------------------------------------
  // Error latched in setup keeps a refused write from landing in access
  wire [31:0] nxt_prdata = i_pwrite ? 32'h00000000 : rd_value;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= setup_err;
    end
  end

  assign o_pready = access_done;
  assign o_prdata = prdata_ff;
  assign o_pslverr = access_done & pslverr_ff;

  // ----------------------------------------------------------------
  // Enable/measure source selection
  // ----------------------------------------------------------------
  wire ch0_src_in = ch0_src_ff & i_timer_input_pin_three;
  wire ch3_src_in =
    (i_ch3_ch4_source_select == SRC_EVENT_BUS2) ? i_input_event_bus[2] :
    (i_ch3_ch4_source_select == SRC_EVENT_BUS3) ? i_input_event_bus[3] :
    1'b0;

  // ----------------------------------------------------------------
  // Capture-capable channels; channels 1 and 2 get no capture unit
  // ----------------------------------------------------------------
  // Channel 0 has no enable bit in this word, so its input is always admitted
  measure_channel u_ch0
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_run(run_ff[RUN_CH0_BIT]),
    .i_tick(i_count_tick),
    .i_mode(ch0_mode_ff),
    .i_ext_enable(1'b1),
    .i_capture(ch0_src_in),
    .o_count(ch0_count),
    .o_measure(ch0_meas),
    .o_captured(ch0_cap)
  );

  measure_channel u_ch3
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_run(run_ff[RUN_CH3_BIT]),
    .i_tick(i_count_tick),
    .i_mode(ch3_mode_ff),
    .i_ext_enable(ch3_een_ff),
    .i_capture(ch3_src_in),
    .o_count(ch3_count),
    .o_measure(ch3_meas),
    .o_captured(ch3_cap)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_ch0_mode_select = ch0_mode_ff;
  assign o_ch1_mode_select = ch1_mode_ff;
  assign o_ch2_mode_select = ch2_mode_ff;
  assign o_ch3_mode_select = ch3_mode_ff;
  assign o_ch3_external_input_enable = ch3_een_ff;
  assign o_ch0_source_select = ch0_src_ff;
  assign o_ch0_measure_input = ch0_src_in;
  // Pin view is gated by the enable; capture still sees the raw source
  assign o_ch3_measure_input = ch3_src_in & ch3_een_ff;
  assign o_ch0_measure = ch0_meas;
  assign o_ch3_measure = ch3_meas;
  assign o_ch0_captured = ch0_cap;
  assign o_ch3_captured = ch3_cap;
endmodule

// [capture_source_model.sv]
// Behavioural model of the external capture pin and input event bus
module capture_source_model
(
  // Clock
  input wire logic i_clock,
  // Capture sources toward the timer block
  output logic o_timer_input_pin_three,
  output logic [3:0] o_input_event_bus
);
  initial
  begin
    o_timer_input_pin_three = 1'b0;
    o_input_event_bus = 4'h0;
  end

  // Line 4 is the pin, 0 to 3 the bus; held 3 cycles so one rise is seen
  task automatic pulse(input int line);
    if (line == 4) o_timer_input_pin_three <= 1'b1;
    else o_input_event_bus[line[1:0]] <= 1'b1;
    repeat (3) @(posedge i_clock);
    if (line == 4) o_timer_input_pin_three <= 1'b0;
    else o_input_event_bus[line[1:0]] <= 1'b0;
  endtask
endmodule

// [mode_control_checker_properties.sv]
// Port-level assertions for the timer group mode control block
module mode_control_checker
  import timer_group_pkg::*;
(
  // Clock, reset and bus
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pslverr,
  // Sources
  input wire logic i_timer_input_pin_three,
  input wire logic [3:0] i_input_event_bus,
  input wire logic [1:0] i_ch3_ch4_source_select,
  // Control and capture outputs
  input wire logic [2:0] o_ch0_mode_select,
  input wire logic [2:0] o_ch1_mode_select,
  input wire logic [2:0] o_ch2_mode_select,
  input wire logic [2:0] o_ch3_mode_select,
  input wire logic o_ch3_external_input_enable,
  input wire logic o_ch0_source_select,
  input wire logic o_ch0_measure_input,
  input wire logic o_ch3_measure_input,
  input wire logic [15:0] o_ch0_measure,
  input wire logic [15:0] o_ch3_measure,
  input wire logic o_ch0_captured,
  input wire logic o_ch3_captured
);
  localparam logic [31:0] MODE_ADDR = {MODE_CTRL_IDX[29:0], 2'b00};
  wire logic access = i_psel & i_penable;
  wire logic mode_wr = access & i_pwrite & (i_paddr == MODE_ADDR);
  wire logic [13:0] ctl = {o_ch0_mode_select, o_ch1_mode_select, o_ch2_mode_select,
    o_ch3_mode_select, o_ch3_external_input_enable, o_ch0_source_select};
  wire logic ch3_src = i_ch3_ch4_source_select[1] &
    i_input_event_bus[{1'b1, i_ch3_ch4_source_select[0]}];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  AST_PSLVERR_PHASE:
    assert property (o_pslverr |-> access) else $error("slave error outside access");
  AST_STRB_REFUSED:
    assert property (mode_wr && i_pstrb[1:0] != 2'b11 |-> o_pslverr ##1 $stable(ctl))
    else $error("partial mode write not refused");
  AST_CH1_BANNED:
    assert property (o_ch1_mode_select[2:1] != 2'b11) else $error("ch1 holds banned mode");
  AST_CH2_BANNED:
    assert property (o_ch2_mode_select[2:1] != 2'b11) else $error("ch2 holds banned mode");
  AST_CTL_BY_WRITE:
    assert property ($changed(ctl) |-> $past(mode_wr)) else $error("mode changed unasked");
  AST_CH0_ROUTE:
    assert property (o_ch0_measure_input == (o_ch0_source_select & i_timer_input_pin_three))
    else $error("ch0 source routing wrong");
  AST_CH3_ROUTE:
    assert property (o_ch3_measure_input == (o_ch3_external_input_enable & ch3_src))
    else $error("ch3 source routing wrong");
  AST_CH0_CAUSE:
    assert property (o_ch0_captured |-> $past(o_ch0_mode_select[2:1]) == 2'b10
      && $past(o_ch0_measure_input) && !$past(o_ch0_measure_input, 2))
    else $error("ch0 capture without cause");
  AST_MEASURE_HOLD:
    assert property ($changed({o_ch0_measure, o_ch3_measure}) |-> o_ch0_captured || o_ch3_captured)
    else $error("measure changed without capture");
endmodule

bind timer_group_mode_control mode_control_checker chk_u
(
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pstrb(i_pstrb), .o_pslverr(o_pslverr),
  .i_timer_input_pin_three(i_timer_input_pin_three), .i_input_event_bus(i_input_event_bus),
  .i_ch3_ch4_source_select(i_ch3_ch4_source_select), .o_ch0_mode_select(o_ch0_mode_select),
  .o_ch1_mode_select(o_ch1_mode_select), .o_ch2_mode_select(o_ch2_mode_select),
  .o_ch3_mode_select(o_ch3_mode_select), .o_ch0_source_select(o_ch0_source_select),
  .o_ch3_external_input_enable(o_ch3_external_input_enable),
  .o_ch0_measure_input(o_ch0_measure_input), .o_ch3_measure_input(o_ch3_measure_input),
  .o_ch0_measure(o_ch0_measure), .o_ch3_measure(o_ch3_measure),
  .o_ch0_captured(o_ch0_captured), .o_ch3_captured(o_ch3_captured)
);

// [tb_top.sv]
// Self-checking bench for the timer group mode control block
module tb_top
  import timer_group_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MA = {MODE_CTRL_IDX[29:0], 2'b00};
  localparam logic [31:0] RUN = {RUN_CTRL_IDX[29:0], 2'b00};
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf, evbus;
  logic [1:0] src_sel = 2'h0;
  logic pready, pslverr, pin3, een, s0, mi0, mi3, cap0, cap3;
  logic [2:0] m0, m1, m2, m3;
  logic [15:0] meas0, meas3;
  int mismatches = 0;
  int checks = 0;

  always #10 clock = ~clock;

  timer_group_mode_control dut_u
  (
    .i_clock(clock), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_count_tick(tick),
    .i_timer_input_pin_three(pin3), .i_input_event_bus(evbus),
    .i_ch3_ch4_source_select(src_sel), .o_ch0_mode_select(m0), .o_ch1_mode_select(m1),
    .o_ch2_mode_select(m2), .o_ch3_mode_select(m3), .o_ch3_external_input_enable(een),
    .o_ch0_source_select(s0), .o_ch0_measure_input(mi0), .o_ch3_measure_input(mi3),
    .o_ch0_measure(meas0), .o_ch3_measure(meas3), .o_ch0_captured(cap0),
    .o_ch3_captured(cap3)
  );
  capture_source_model src_u
  (
    .i_clock(clock), .o_timer_input_pin_three(pin3), .o_input_event_bus(evbus)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] adr(input logic [31:0] idx);
    adr = {idx[29:0], 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Entered just after an edge; leaves one idle edge so strobes never double up
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic err, output logic [31:0] rd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // Waits for ready however long; only the watchdog ends a hang
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    check("pready wait", 32'h1, n);
    check("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, 4'hf, 1'b0, x);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, 4'hf, 1'b0, x);
    check(what, exp, x);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk("mode word", MA, 32'h0);
    check("mode outputs", 32'h0, {18'h0, m0, m1, m2, m3, een, s0});
  endtask

  task automatic t_modes;
    logic [2:0] c12;
    c12 = 3'h0;
    for (int k = 0; k < 8; k++)
    begin
      if (k < 6) c12 = k[2:0];
      wr(MA, {16'h0, k[2:0], 1'b1, k[2:0], 1'b1, k[2:0], 1'b1, k[2:0], 1'b1});
      rd_chk("mode word", MA, {16'h0, k[2:0], 1'b1, c12, 1'b0, c12, 1'b0, k[2:0], 1'b1});
      check("ch0 ch3 modes", {26'h0, k[2:0], k[2:0]}, {26'h0, m0, m3});
      check("ch1 ch2 modes", {26'h0, c12, c12}, {26'h0, m1, m2});
      check("enable and source", 32'h3, {30'h0, een, s0});
    end
    wr(MA, 32'h0);
    check("enable and source", 32'h0, {30'h0, een, s0});
  endtask

  task automatic t_refuse;
    logic [31:0] x;
    wr(MA, 32'h2000);
    apb(1'b1, MA, 32'h4000, 4'h1, 1'b1, x);
    rd_chk("mode word kept", MA, 32'h2000);
    apb(1'b0, adr(MODE_CTRL_IDX + 32'h1), 32'h0, 4'hf, 1'b1, x);
    check("unmapped read", 32'h0, x);
    apb(1'b1, adr(MEAS_CH0_IDX), 32'h1234, 4'hf, 1'b1, x);
    wr(MA, 32'h0);
  endtask

  // Ticks stop before the count is read, so the value cannot move under the capture
  task automatic capture(input logic [31:0] midx, input logic [31:0] cidx, input int line,
    input int ticks, input logic reload, input string what);
    logic [31:0] c;
    logic ch0;
    logic [31:0] flag;
    ch0 = (midx == MEAS_CH0_IDX);
    flag = ch0 ? 32'h1 << STAT_CH0_CAP_BIT : 32'h1 << STAT_CH3_CAP_BIT;
    tick <= 1'b1;
    repeat (ticks) @(posedge clock);
    tick <= 1'b0;
    @(posedge clock);
    apb(1'b0, adr(cidx), 32'h0, 4'hf, 1'b0, c);
    src_u.pulse(line);
    repeat (3) @(posedge clock);
    rd_chk({what, " measure"}, adr(midx), c);
    rd_chk({what, " count"}, adr(cidx), reload ? 32'hffff : c);
    check({what, " port"}, c, {16'h0, ch0 ? meas0 : meas3});
    rd_chk({what, " status"}, adr(STATUS_IDX), flag);
    wr(adr(STATUS_IDX), 32'hf);
    rd_chk({what, " status clear"}, adr(STATUS_IDX), 32'h0);
  endtask

  task automatic t_capture;
    wr(MA, 32'h9000);
    wr(RUN, 32'h1);
    capture(MEAS_CH0_IDX, COUNT_CH0_IDX, 4, 7, 1'b1, "ch0 clear");
    wr(RUN, 32'h0);
    wr(MA, 32'hb000);
    wr(RUN, 32'h1);
    capture(MEAS_CH0_IDX, COUNT_CH0_IDX, 4, 5, 1'b0, "ch0 free");
    wr(RUN, 32'h0);
    src_sel <= 2'h2;
    wr(MA, 32'h0008);
    wr(RUN, 32'h8);
    capture(MEAS_CH3_IDX, COUNT_CH3_IDX, 2, 5, 1'b0, "ch3 gated");
    wr(RUN, 32'h0);
    src_sel <= 2'h3;
    wr(MA, 32'h0009);
    wr(RUN, 32'h8);
    capture(MEAS_CH3_IDX, COUNT_CH3_IDX, 3, 6, 1'b1, "ch3 enabled");
    wr(RUN, 32'h0);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_modes;
    t_refuse;
    t_capture;
    test_done;
  end

  initial
  begin
    repeat (3000) @(posedge clock);
    mismatches++;
    test_done;
  end
endmodule
